// ===== logic/rsc_pkg.sv
`default_nettype none
package rsc_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [5:0] RSC_NEXT_STATE_ADDR = 6'h17;
    localparam logic [5:0] RSC_AUTOCAL_ADDR    = 6'h18;

    localparam int         RSC_CLEAR_LSB = 4;
    localparam int         RSC_RXOFF_LSB = 2;
    localparam int         RSC_TXOFF_LSB = 0;
    localparam int         RSC_ACAL_LSB = 4;

    localparam logic [1:0] RSC_CLEAR_RESET = 2'h3;
    localparam logic [1:0] RSC_RXOFF_RESET = 2'h0;
    localparam logic [1:0] RSC_TXOFF_RESET = 2'h0;
    localparam logic [1:0] RSC_ACAL_RESET  = 2'h0;

    localparam logic [1:0] RSC_ACAL_NEVER   = 2'h0;
    localparam logic [1:0] RSC_ACAL_LEAVE   = 2'h1;
    localparam logic [1:0] RSC_ACAL_RETURN  = 2'h2;
    localparam logic [1:0] RSC_ACAL_FOURTH  = 2'h3;
    localparam int         RSC_ACAL_RETURN_PERIOD = 4;

    localparam logic [1:0] RSC_CLEAR_ALWAYS = 2'h0;
    localparam logic [1:0] RSC_CLEAR_RSSI   = 2'h1;
    localparam logic [1:0] RSC_CLEAR_NOT_RX = 2'h2;

    localparam logic [1:0] RSC_NEXT_IDLE    = 2'h0;
    localparam logic [1:0] RSC_NEXT_FSTX    = 2'h1;
    localparam logic [1:0] RSC_NEXT_TX      = 2'h2;
    localparam logic [1:0] RSC_NEXT_RX      = 2'h3;
    localparam logic [1:0] RSC_TXNEXT_STAY  = 2'h2;
    localparam logic [1:0] RSC_TXNEXT_RX    = 2'h3;

    typedef enum logic [2:0] {
        RSC_IDLE,
        RSC_RX,
        RSC_TX,
        RSC_SYNTH_READY,
        RSC_CAL
    } rsc_state_type;

    typedef struct packed {
        logic go_rx;
        logic go_tx;
        logic go_synth_ready_for_transmit;
        logic go_idle;
        logic calibrate;
    } rsc_strobe_type;

    typedef struct packed {
        logic rx_packet_done;
        logic tx_packet_done;
        logic cal_done;
    } rsc_event_type;
endpackage : rsc_pkg
`default_nettype wire

// ===== logic/rsc_autocal.sv
`default_nettype none
module rsc_autocal
    import rsc_pkg::*;
#(
    parameter int RETURN_PERIOD = 4
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic [1:0] synth_autocal_when,
    input  wire logic       leave_idle,
    input  wire logic       auto_return,
    output logic            cal_needed
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CW = $clog2(RETURN_PERIOD);
    localparam logic [CW-1:0] LAST = CW'(RETURN_PERIOD - 1);

    logic [CW-1:0] return_count_reg;

    // The counter wraps by itself, which only lands on the period for a power of two.
    if (RETURN_PERIOD < 2 || (RETURN_PERIOD & (RETURN_PERIOD - 1)) != 0) begin : g_bad_period
        $error("RETURN_PERIOD must be a power of two of at least 2.");
    end

    // The count only advances in the every-fourth mode; leaving that mode holds the count, and only reset clears it.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            return_count_reg <= '0;
        end else if (auto_return && synth_autocal_when == RSC_ACAL_FOURTH) begin
            return_count_reg <= return_count_reg + CW'(1);
        end
    end

    always_comb begin
        unique case (synth_autocal_when)
            RSC_ACAL_NEVER:  cal_needed = 1'b0;
            RSC_ACAL_LEAVE:  cal_needed = leave_idle;
            RSC_ACAL_RETURN: cal_needed = auto_return;
            RSC_ACAL_FOURTH: cal_needed = auto_return && return_count_reg == LAST;
        endcase
    end
endmodule // rsc_autocal
`default_nettype wire

// ===== logic/rsc_radio_sequencer.sv
// Notes on behaviour
// - Clear-channel mode bits 5:4, reset 3; 0 always.
// - Mode 1: clear while signal below threshold.
// - Mode 2: clear unless receiving a packet.
// - Mode 3: below threshold and not receiving.
// - After-receive field bits 3:2, resets to 0.
// - After receive: idle, synth-ready, transmit, stay.
// - After-transmit field bits 1:0, resets to 0.
// - After transmit: idle, synth-ready, stay, receive.
// - Transmit stay restarts preamble immediately.
// - Autocal field bits 5:4 second register, reset 0.
// - Autocal 1: calibrate when leaving idle.
// - Autocal 2: calibrate on automatic return idle.
// - Autocal 3: every fourth automatic return calibrates.
`default_nettype none
module rsc_radio_sequencer
    import rsc_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           reset,
    input  wire logic           cfg_wr_en,
    input  wire logic           cfg_rd_en,
    input  wire logic [5:0]     cfg_addr,
    input  wire logic [7:0]     cfg_wdata,
    output logic      [7:0]     cfg_rdata,
    input  wire rsc_strobe_type strobe,
    input  wire rsc_event_type  event_in,
    input  wire logic           rssi_below_threshold,
    input  wire logic           receiving_packet,
    output logic                clear_channel_flag,
    output rsc_state_type       radio_state,
    output logic                cal_start,
    output logic                preamble_restart
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0]    clear_channel_select_reg;
    logic [1:0]    after_receive_state_reg;
    logic [1:0]    after_transmit_state_reg;
    logic [1:0]    synth_autocal_when_reg;
    rsc_state_type state_reg;
    rsc_state_type state_next;
    rsc_state_type cal_target_reg;
    rsc_state_type target;
    logic          leave_idle;
    logic          auto_return;
    logic          cal_needed;
    logic          go_cal;
    logic          clear_next;
    logic          cal_entry;
    logic          tx_stay;

    function automatic rsc_state_type rx_next(input logic [1:0] sel);
        unique case (sel)
            RSC_NEXT_IDLE: rx_next = RSC_IDLE;
            RSC_NEXT_FSTX: rx_next = RSC_SYNTH_READY;
            RSC_NEXT_TX:   rx_next = RSC_TX;
            RSC_NEXT_RX:   rx_next = RSC_RX;
        endcase
    endfunction

    function automatic rsc_state_type tx_next(input logic [1:0] sel);
        unique case (sel)
            RSC_NEXT_IDLE:   tx_next = RSC_IDLE;
            RSC_NEXT_FSTX:   tx_next = RSC_SYNTH_READY;
            RSC_TXNEXT_STAY: tx_next = RSC_TX;
            RSC_TXNEXT_RX:   tx_next = RSC_RX;
        endcase
    endfunction

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clear_channel_select_reg <= RSC_CLEAR_RESET;
            after_receive_state_reg  <= RSC_RXOFF_RESET;
            after_transmit_state_reg <= RSC_TXOFF_RESET;
        end else if (cfg_wr_en && cfg_addr == RSC_NEXT_STATE_ADDR) begin
            clear_channel_select_reg <= cfg_wdata[RSC_CLEAR_LSB +: 2];
            after_receive_state_reg  <= cfg_wdata[RSC_RXOFF_LSB +: 2];
            after_transmit_state_reg <= cfg_wdata[RSC_TXOFF_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            synth_autocal_when_reg <= RSC_ACAL_RESET;
        end else if (cfg_wr_en && cfg_addr == RSC_AUTOCAL_ADDR) begin
            synth_autocal_when_reg <= cfg_wdata[RSC_ACAL_LSB +: 2];
        end
    end

    // Read data is registered, so it appears one cycle after the read request.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd_en) begin
            unique case (cfg_addr)
                RSC_NEXT_STATE_ADDR: cfg_rdata <= {2'h0, clear_channel_select_reg,
                    after_receive_state_reg, after_transmit_state_reg};
                RSC_AUTOCAL_ADDR: cfg_rdata <= {2'h0, synth_autocal_when_reg, 4'h0};
                default: cfg_rdata <= 8'h00;
            endcase
        end
    end

    always_comb begin
        unique case (clear_channel_select_reg)
            RSC_CLEAR_ALWAYS: clear_next = 1'b1;
            RSC_CLEAR_RSSI:   clear_next = rssi_below_threshold;
            RSC_CLEAR_NOT_RX: clear_next = !receiving_packet;
            default:        clear_next = rssi_below_threshold && !receiving_packet;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clear_channel_flag <= 1'b1;
        end else begin
            clear_channel_flag <= clear_next;
        end
    end

    // Where the radio would go now, ignoring calibration.
    always_comb begin
        target      = state_reg;
        leave_idle  = 1'b0;
        auto_return = 1'b0;
        unique case (state_reg)
            RSC_IDLE: begin
                if (strobe.go_rx) begin
                    target = RSC_RX;
                end else if (strobe.go_tx) begin
                    target = RSC_TX;
                end else if (strobe.go_synth_ready_for_transmit) begin
                    target = RSC_SYNTH_READY;
                end
                leave_idle = target != RSC_IDLE;
            end
            RSC_RX: begin
                if (strobe.go_idle) begin
                    target = RSC_IDLE;
                end else if (event_in.rx_packet_done) begin
                    target      = rx_next(after_receive_state_reg);
                    auto_return = target == RSC_IDLE;
                end else if (strobe.go_tx) begin
                    target = RSC_TX;
                end
            end
            RSC_TX: begin
                if (strobe.go_idle) begin
                    target = RSC_IDLE;
                end else if (event_in.tx_packet_done) begin
                    target      = tx_next(after_transmit_state_reg);
                    auto_return = target == RSC_IDLE;
                end
            end
            RSC_SYNTH_READY: begin
                if (strobe.go_idle) begin
                    target = RSC_IDLE;
                end else if (strobe.go_tx) begin
                    target = RSC_TX;
                end else if (strobe.go_rx) begin
                    target = RSC_RX;
                end
            end
            RSC_CAL: target = state_reg;
        endcase
    end

    rsc_autocal #(
        .RETURN_PERIOD (RSC_ACAL_RETURN_PERIOD)
    ) u_autocal (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .synth_autocal_when (synth_autocal_when_reg),
        .leave_idle         (leave_idle),
        .auto_return        (auto_return),
        .cal_needed         (cal_needed)
    );

    // A manual calibration is only honoured from idle, where the synthesizer is free.
    assign go_cal = cal_needed ||
        (state_reg == RSC_IDLE && target == RSC_IDLE && strobe.calibrate);

    always_comb begin
        state_next = target;
        if (state_reg == RSC_CAL) begin
            state_next = event_in.cal_done ? cal_target_reg : RSC_CAL;
        end else if (go_cal) begin
            state_next = RSC_CAL;
        end
    end

    assign cal_entry = state_reg != RSC_CAL && go_cal;
    assign tx_stay   = state_reg == RSC_TX && !strobe.go_idle &&
        event_in.tx_packet_done && target == RSC_TX;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= RSC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cal_target_reg <= RSC_IDLE;
        end else if (cal_entry) begin
            cal_target_reg <= target;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cal_start <= 1'b0;
        end else begin
            cal_start <= cal_entry;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            preamble_restart <= 1'b0;
        end else begin
            preamble_restart <= tx_stay;
        end
    end

    assign radio_state = state_reg;
endmodule // rsc_radio_sequencer
`default_nettype wire

// ===== verif/rsc_radio_sequencer_props.sv
`default_nettype none
module rsc_radio_sequencer_props
    import rsc_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           reset,
    input wire logic           cfg_wr_en,
    input wire logic           cfg_rd_en,
    input wire logic [5:0]     cfg_addr,
    input wire logic [7:0]     cfg_wdata,
    input wire logic [7:0]     cfg_rdata,
    input wire rsc_strobe_type strobe,
    input wire rsc_event_type  event_in,
    input wire logic           rssi_below_threshold,
    input wire logic           receiving_packet,
    input wire logic           clear_channel_flag,
    input wire rsc_state_type  radio_state,
    input wire logic           cal_start,
    input wire logic           preamble_restart
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ns_reg;
    logic [7:0] ac_reg;
    logic [7:0] rd_exp;
    logic       rx_end;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Shadow copies hold the modes, since only the ports are visible here.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ns_reg <= 8'h30;
            ac_reg <= 8'h00;
        end else if (cfg_wr_en && cfg_addr == RSC_NEXT_STATE_ADDR) begin
            ns_reg <= cfg_wdata & 8'h3F;
        end else if (cfg_wr_en && cfg_addr == RSC_AUTOCAL_ADDR) begin
            ac_reg <= cfg_wdata & 8'h30;
        end
    end
    assign rd_exp = cfg_addr == RSC_NEXT_STATE_ADDR ? ns_reg :
                    cfg_addr == RSC_AUTOCAL_ADDR ? ac_reg : 8'h00;
    assign rx_end = radio_state == RSC_RX && event_in.rx_packet_done && !strobe.go_idle;
    a_read_back: assert property (cfg_rd_en |=> cfg_rdata == $past(rd_exp))
        else $error("read data wrong");
    a_clear_rssi: assert property (ns_reg[5:4] == 2'h1 |=>
        clear_channel_flag == $past(rssi_below_threshold)) else $error("flag wrong in mode 1");
    a_clear_both: assert property (ns_reg[5:4] == 2'h3 |=>
        clear_channel_flag == $past(rssi_below_threshold && !receiving_packet))
        else $error("flag wrong in mode 3");
    a_rx_to_tx: assert property (rx_end && ns_reg[3:2] == 2'h2 |=> radio_state == RSC_TX)
        else $error("no transmit after receive");
    a_tx_stay: assert property (radio_state == RSC_TX && event_in.tx_packet_done &&
        !strobe.go_idle && ns_reg[1:0] == 2'h2 |=> radio_state == RSC_TX && preamble_restart)
        else $error("transmit did not restart");
    a_leave_cal: assert property (ac_reg[5:4] == 2'h1 && radio_state == RSC_IDLE &&
        strobe.go_rx |=> radio_state == RSC_CAL && cal_start) else $error("no calibration");
    a_return_cal: assert property (ac_reg[5:4] == 2'h2 && rx_end && ns_reg[3:2] == 2'h0
        |=> radio_state == RSC_CAL && cal_start) else $error("no calibration on return");
    a_no_autocal: assert property (ac_reg[5:4] == 2'h0 &&
        !(radio_state == RSC_IDLE && strobe.calibrate) |=> !cal_start)
        else $error("calibration without strobe");
    a_clear_always: assert property (ns_reg[5:4] == 2'h0 |=> clear_channel_flag)
        else $error("flag wrong in mode 0");
    a_clear_not_rx: assert property (ns_reg[5:4] == 2'h2 |=>
        clear_channel_flag == !$past(receiving_packet)) else $error("flag wrong in mode 2");
    a_tx_to_rx: assert property (radio_state == RSC_TX && event_in.tx_packet_done &&
        !strobe.go_idle && ns_reg[1:0] == 2'h3 |=> radio_state == RSC_RX)
        else $error("no receive after transmit");
endmodule // rsc_radio_sequencer_props
bind rsc_radio_sequencer rsc_radio_sequencer_props i_props (
    .clk_sys(clk_sys), .reset(reset), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .strobe(strobe),
    .event_in(event_in), .rssi_below_threshold(rssi_below_threshold),
    .receiving_packet(receiving_packet), .clear_channel_flag(clear_channel_flag),
    .radio_state(radio_state), .cal_start(cal_start), .preamble_restart(preamble_restart)
);
`default_nettype wire

// ===== verif/test_rsc_radio_sequencer.sv
`default_nettype none
module test_rsc_radio_sequencer
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic           clk_sys = 1'b0;
    logic           reset = 1'b1;
    logic           wr_en = 1'b0;
    logic           rd_en = 1'b0;
    logic [5:0]     addr = 6'h00;
    logic [7:0]     wdata = 8'h00;
    logic [7:0]     rdata;
    rsc_strobe_type strobe = '0;
    rsc_event_type  event_in = '0;
    logic           rssi = 1'b0;
    logic           busy_rx = 1'b0;
    logic           flag;
    rsc_state_type  state;
    logic           cal_start;
    logic           restart;
    logic [7:0]     rnd;
    int             n_mismatch = 0;
    int             checked = 0;
    int             cycles = 0;
    rsc_radio_sequencer i_dut (
        .clk_sys(clk_sys), .reset(reset), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en),
        .cfg_addr(addr), .cfg_wdata(wdata), .cfg_rdata(rdata), .strobe(strobe),
        .event_in(event_in), .rssi_below_threshold(rssi), .receiving_packet(busy_rx),
        .clear_channel_flag(flag), .radio_state(state), .cal_start(cal_start),
        .preamble_restart(restart)
    );
    initial forever #5 clk_sys = ~clk_sys;
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Strobes, events and the config bus are set once per cycle, so a pulse lasts exactly one edge.
    task automatic drv(input logic [4:0] s, input logic [2:0] e, input logic w, input logic r,
                       input logic [5:0] a, input logic [7:0] d);
        strobe = s;
        event_in = e;
        wr_en = w;
        rd_en = r;
        addr = a;
        wdata = d;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input logic [4:0] s, input logic [2:0] e);
        drv(s, e, 1'b0, 1'b0, 6'h00, 8'h00);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        drv(5'h00, 3'h0, 1'b1, 1'b0, a, d);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        drv(5'h00, 3'h0, 1'b0, 1'b1, a, 8'h00);
        pulse(5'h00, 3'h0);
        chk(rdata, exp, "rdata");
    endtask
    task automatic st(input rsc_state_type t);
        chk(8'(state), 8'(t), "state");
    endtask
    function automatic rsc_state_type next_of(input logic [1:0] v);
        rsc_state_type t[4] = '{RSC_IDLE, RSC_SYNTH_READY, RSC_TX, RSC_RX};
        return t[v];
    endfunction
    function automatic logic clear_of(input logic [1:0] m, input logic r, input logic p);
        return (m[0] ? r : 1'b1) & (m[1] ? !p : 1'b1);
    endfunction
    task automatic do_reset();
        reset = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b0;
    endtask
    task automatic ret(input logic cal);
        pulse(5'h10, 3'h0);
        pulse(5'h00, 3'h4);
        chk(cal_start, cal, "cal_start");
        if (cal) begin
            pulse(5'h00, 3'h1);
        end
        st(RSC_IDLE);
    endtask
    initial begin
        void'($urandom(32'h097BD90E));
        do_reset();
        rd_chk(RSC_NEXT_STATE_ADDR, 8'h30);
        rd_chk(RSC_AUTOCAL_ADDR, 8'h00);
        rd_chk(6'h3F, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = 8'($urandom());
            wr(RSC_NEXT_STATE_ADDR, rnd);
            rd_chk(RSC_NEXT_STATE_ADDR, rnd & 8'h3F);
            wr(RSC_AUTOCAL_ADDR, rnd);
            rd_chk(RSC_AUTOCAL_ADDR, rnd & 8'h30);
        end
        for (int m = 0; m < 4; m++) begin
            wr(RSC_NEXT_STATE_ADDR, 8'(m << 4));
            for (int k = 0; k < 8; k++) begin
                rssi = 1'($urandom());
                busy_rx = 1'($urandom());
                pulse(5'h00, 3'h0);
                chk(flag, clear_of(2'(m), rssi, busy_rx), "flag");
            end
        end
        wr(RSC_AUTOCAL_ADDR, 8'h00);
        for (int v = 0; v < 4; v++) begin
            wr(RSC_NEXT_STATE_ADDR, 8'(v * 5));
            pulse(5'h10, 3'h0);
            pulse(5'h00, 3'h4);
            st(next_of(2'(v)));
            pulse(5'h02, 3'h0);
            pulse(5'h08, 3'h0);
            pulse(5'h00, 3'h2);
            st(next_of(2'(v)));
            chk(restart, 1'(v == 2), "restart");
            pulse(5'h02, 3'h0);
        end
        pulse(5'h01, 3'h0);
        st(RSC_CAL);
        pulse(5'h00, 3'h1);
        wr(RSC_AUTOCAL_ADDR, 8'h10);
        pulse(5'h10, 3'h0);
        chk(cal_start, 1'b1, "cal_start");
        pulse(5'h04, 3'h0);
        st(RSC_CAL);
        pulse(5'h00, 3'h1);
        st(RSC_RX);
        pulse(5'h02, 3'h0);
        pulse(5'h04, 3'h0);
        chk(cal_start, 1'b1, "cal_start");
        pulse(5'h00, 3'h1);
        st(RSC_SYNTH_READY);
        pulse(5'h08, 3'h0);
        chk(cal_start, 1'b0, "cal_start");
        st(RSC_TX);
        pulse(5'h02, 3'h0);
        wr(RSC_NEXT_STATE_ADDR, 8'h30);
        wr(RSC_AUTOCAL_ADDR, 8'h20);
        ret(1'b1);
        wr(RSC_AUTOCAL_ADDR, 8'h30);
        ret(1'b0);
        ret(1'b0);
        // A reset in mid-count must throw the two returns above away.
        do_reset();
        wr(RSC_AUTOCAL_ADDR, 8'h30);
        for (int i = 1; i <= 8; i++) begin
            ret(1'(i % 4 == 0));
        end
        close_out();
    end
endmodule // test_rsc_radio_sequencer
`default_nettype wire
